// ---- rtl/mfb_core.sv ----
// Purpose: Pin-level bus interface of a muxed address/data flash device
// Assumes: Pins come from outside the clock domain; core side is local
// Notes:   The flash clock pin is sampled, its edges found by comparison
// Overview of operation
// RQ1: Active only while chip select low and hard reset high
// RQ2: Chip select high deselects, tri-states data, enters standby
// RQ3: Output enable gates read data onto the muxed bus
// RQ4: Write captures data and address on first rising chip select or strobe
// RQ5: Guard low: protection of locked-down blocks cannot change
// RQ6: Guard high: locked-down blocks may be locked or unlocked
// RQ7: Hard reset low holds reset mode, outputs tri-stated
// RQ8: Leaving hard reset all blocks locked, configuration at defaults
// RQ9: Async read after reset; data valid after chip select or latch fall
// RQ10: Address latch transparent while latch low, holds from its rise
// RQ11: Sync reads capture address on configured clock edge with latch low
// RQ12: Clock ignored in async reads and all writes
// RQ13: Wait flags valid data in sync reads; tri-state when deselected
// RQ14: Wait asserts in the wait cycle or one clock earlier
// RQ15: Wait held deasserted while output enable high
// RQ16: Supply in lockout blocks program and erase; normal range allows
// RQ17: Supply sampled only at program or erase start
// RQ18: Read needs chip select and output enable low; data per last command
// RQ19: Write begins with chip select and strobe low, output enable high
// RQ20: Host latches address first and holds latch high through the write
// RQ21: Host presents address with chip select and latch low together
// RQ22: Chip select high during program or erase: finish, then standby
// RQ23: Hard reset during program or erase aborts it
// RQ24: Supply given as lockout, normal and high level status inputs
`timescale 1ns/1ps
module mfb_core (
   input  wire logic                          clock_in,
   input  wire logic                          rst_in,
   input  wire logic                          chip_sel_n_in,
   input  wire logic                          out_en_n_in,
   input  wire logic                          cmd_strobe_n_in,
   input  wire logic                          latch_n_in,
   input  wire logic                          hard_reset_n_in,
   input  wire logic                          flash_clk_in,
   input  wire logic                          lockdown_guard_in,
   input  wire logic [mfb_pkg::BUS_W-1:0]     muxed_addr_data_bus_in,
   output logic      [mfb_pkg::BUS_W-1:0]     muxed_addr_data_bus_out,
   output logic                               muxed_addr_data_bus_oe_out,
   input  wire logic [mfb_pkg::UPPER_W-1:0]   upper_address_lines_in,
   output logic                               wait_out,
   output logic                               wait_oe_out,
   input  wire logic                          program_lockout_level_in,
   input  wire logic                          program_normal_level_in,
   input  wire logic                          program_high_level_in,
   input  wire logic [mfb_pkg::BUS_W-1:0]     read_data_in,
   input  wire logic                          wait_now_in,
   input  wire logic                          wait_next_in,
   input  wire logic                          cfg_load_in,
   input  wire logic                          cfg_sync_in,
   input  wire logic                          cfg_rise_in,
   input  wire logic                          cfg_early_in,
   input  wire logic                          lock_req_in,
   input  wire mfb_pkg::mfb_lock_op_type      lock_op_in,
   input  wire logic [mfb_pkg::BLK_W-1:0]     lock_block_in,
   input  wire logic                          pe_start_in,
   input  wire logic                          pe_done_in,
   input  wire logic [mfb_pkg::BLK_W-1:0]     pe_block_in,
   output logic [mfb_pkg::ADDR_W-1:0]         addr_out,
   output logic                               wr_strobe_out,
   output logic [mfb_pkg::ADDR_W-1:0]         wr_addr_out,
   output logic [mfb_pkg::BUS_W-1:0]          wr_data_out,
   output logic                               active_out,
   output logic                               standby_out,
   output logic                               reset_mode_out,
   output logic                               data_valid_out,
   output logic                               sync_mode_out,
   output logic                               lock_refused_out,
   output logic [1:0]                         lock_state_out,
   output logic                               pe_busy_out,
   output logic                               pe_refused_out,
   output logic                               pe_abort_out,
   output logic                               pe_high_supply_out
);
   import mfb_pkg::*;

   function automatic logic [PIN_W-1:0] settle(input logic [PIN_W-1:0] a,
                                               input logic [PIN_W-1:0] b,
                                               input logic [PIN_W-1:0] old);
      settle = (a & b) | (old & (a ^ b));
   endfunction

   function automatic logic blk_ok(input logic [BLK_W-1:0] b);
      blk_ok = (32'(b) < NUM_BLOCKS);
   endfunction

   // Pin sampling: stage one feeds only stage two
   logic [PIN_W-1:0] s1_q, s2_q, s3_q, st_q, pv_q;
   logic [PIN_W-1:0] st_d;
   logic [PIN_W-1:0] pin_raw;

   assign pin_raw = {upper_address_lines_in, muxed_addr_data_bus_in,
                     lockdown_guard_in, flash_clk_in, hard_reset_n_in,
                     latch_n_in, cmd_strobe_n_in, out_en_n_in, chip_sel_n_in};

   always_comb begin
      st_d = settle(s2_q, s3_q, st_q);
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         s1_q <= {{(BUS_W + UPPER_W){1'b0}}, CTL_IDLE};
         s2_q <= {{(BUS_W + UPPER_W){1'b0}}, CTL_IDLE};
         s3_q <= {{(BUS_W + UPPER_W){1'b0}}, CTL_IDLE};
         st_q <= {{(BUS_W + UPPER_W){1'b0}}, CTL_IDLE};
         pv_q <= {{(BUS_W + UPPER_W){1'b0}}, CTL_IDLE};
      end else begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         st_q <= st_d;
         pv_q <= st_q;
      end
   end

   // Settled pin views
   logic cs_n, oe_n, we_n, lat_n, hr, wp;
   logic [BUS_W-1:0]  bus_v, bus_p;
   logic [ADDR_W-1:0] addr_in;
   logic clk_rise, clk_fall, cs_fall, lat_fall, sel;
   assign cs_n     = st_q[P_CS];
   assign oe_n     = st_q[P_OE];
   assign we_n     = st_q[P_WE];
   assign lat_n    = st_q[P_LAT];
   assign hr       = st_q[P_RST];
   assign wp       = st_q[P_WP];
   assign bus_v    = st_q[P_BUS +: BUS_W];
   assign bus_p    = pv_q[P_BUS +: BUS_W];
   assign addr_in  = {st_q[P_UPR +: UPPER_W], bus_v};
   assign clk_rise = st_q[P_CLK] & ~pv_q[P_CLK];
   assign clk_fall = ~st_q[P_CLK] & pv_q[P_CLK];
   assign cs_fall  = ~cs_n & pv_q[P_CS];
   assign lat_fall = ~lat_n & pv_q[P_LAT];
   assign sel      = ~cs_n & hr; // RQ1

   // Bus, configuration and program/erase group
   logic cfg_sync_q, cfg_rise_q, cfg_early_q;
   logic cfg_sync_d, cfg_rise_d, cfg_early_d;
   logic wr_act_q, wr_act_d, wr_end, clk_edge;
   logic [ADDR_W-1:0] addr_d, wr_addr_d;
   logic [BUS_W-1:0]  bus_out_d, wr_data_d;
   logic bus_oe_d, wait_d, wait_oe_d, wr_strobe_d, ok_d;
   logic active_d, standby_d, blk_locked;
   logic pe_ref_d, pe_abort_d, pe_high_d;
   mfb_pe_state_type pe_q, pe_d;
   logic [NUM_BLOCKS-1:0] lock_q, lock_d, ldown_q, ldown_d;
   logic lock_ref_d;
   logic [1:0] lock_st_d;

   assign wr_end   = wr_act_q & (cs_n | we_n);
   assign clk_edge = cfg_rise_q ? clk_rise : clk_fall;
   assign blk_locked = blk_ok(pe_block_in) ? lock_q[pe_block_in] : 1'b1;

   always_comb begin
      cfg_sync_d  = cfg_sync_q;
      cfg_rise_d  = cfg_rise_q;
      cfg_early_d = cfg_early_q;
      addr_d      = addr_out;
      wr_addr_d   = wr_addr_out;
      wr_data_d   = wr_data_out;
      wr_strobe_d = 1'b0;
      ok_d        = data_valid_out;
      pe_d        = pe_q;
      pe_ref_d    = 1'b0;
      pe_abort_d  = 1'b0;
      pe_high_d   = pe_high_supply_out;
      if (!hr) begin
         cfg_sync_d  = CFG_SYNC_RST; // RQ8
         cfg_rise_d  = CFG_RISE_RST; // RQ8
         cfg_early_d = CFG_EARLY_RST; // RQ8
         ok_d        = 1'b0; // RQ9
      end else begin
         if (cfg_load_in) begin
            cfg_sync_d  = cfg_sync_in;
            cfg_rise_d  = cfg_rise_in;
            cfg_early_d = cfg_early_in;
         end
         if (cs_fall || lat_fall) begin
            ok_d = 1'b1; // RQ9
         end
         // Clock edges count only in sync mode outside writes
         if (!cfg_sync_q && !lat_n) begin
            addr_d = addr_in; // RQ10 RQ21
         end else if (cfg_sync_q && !lat_n && !wr_act_q && clk_edge) begin
            addr_d = addr_in; // RQ11 RQ12
         end
         if (wr_end) begin
            // Data before the edge is used; the edge sample may be late
            wr_strobe_d = 1'b1; // RQ4
            wr_addr_d   = addr_out; // RQ20
            wr_data_d   = bus_p; // RQ4
         end
      end
      wr_act_d = sel & ~we_n & oe_n; // RQ19
      // Read drives only once a falling select or latch has been seen
      bus_oe_d  = sel & ~oe_n & we_n & lat_n & data_valid_out; // RQ3 RQ18
      bus_out_d = read_data_in; // RQ18
      wait_oe_d = sel; // RQ13
      wait_d    = WAIT_OFF; // RQ15
      if (!oe_n && cfg_sync_q) begin
         wait_d = cfg_early_q ? wait_next_in : wait_now_in; // RQ14
      end
      active_d  = sel; // RQ1
      // Chip select high during a run waits for the run to end
      standby_d = hr & cs_n & (pe_q == PE_IDLE); // RQ2 RQ22
      unique case (pe_q)
         PE_IDLE: begin
            if (hr && pe_start_in) begin
               // Supply level is looked at only here
               if (program_lockout_level_in ||
                   !(program_normal_level_in || program_high_level_in) ||
                   blk_locked) begin
                  pe_ref_d = 1'b1; // RQ16 RQ24
               end else begin
                  pe_d      = PE_RUN; // RQ17
                  pe_high_d = program_high_level_in; // RQ17 RQ24
               end
            end
         end
         PE_RUN: begin
            if (!hr) begin
               pe_d       = PE_IDLE; // RQ23
               pe_abort_d = 1'b1; // RQ23
            end else if (pe_done_in) begin
               pe_d = PE_IDLE; // RQ22
            end
         end
      endcase
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         cfg_sync_q                 <= CFG_SYNC_RST;
         cfg_rise_q                 <= CFG_RISE_RST;
         cfg_early_q                <= CFG_EARLY_RST;
         wr_act_q                   <= 1'b0;
         addr_out                   <= '0;
         wr_addr_out                <= '0;
         wr_data_out                <= '0;
         wr_strobe_out              <= 1'b0;
         muxed_addr_data_bus_out    <= '0;
         muxed_addr_data_bus_oe_out <= 1'b0;
         wait_out                   <= WAIT_OFF;
         wait_oe_out                <= 1'b0;
         active_out                 <= 1'b0;
         standby_out                <= 1'b0;
         reset_mode_out             <= 1'b0;
         data_valid_out             <= 1'b0;
         sync_mode_out              <= CFG_SYNC_RST;
         pe_q                       <= PE_IDLE;
         pe_busy_out                <= 1'b0;
         pe_refused_out             <= 1'b0;
         pe_abort_out               <= 1'b0;
         pe_high_supply_out         <= 1'b0;
      end else begin
         cfg_sync_q                 <= cfg_sync_d;
         cfg_rise_q                 <= cfg_rise_d;
         cfg_early_q                <= cfg_early_d;
         wr_act_q                   <= wr_act_d;
         addr_out                   <= addr_d;
         wr_addr_out                <= wr_addr_d;
         wr_data_out                <= wr_data_d;
         wr_strobe_out              <= wr_strobe_d;
         muxed_addr_data_bus_out    <= bus_out_d;
         muxed_addr_data_bus_oe_out <= bus_oe_d;
         wait_out                   <= wait_d;
         wait_oe_out                <= wait_oe_d;
         active_out                 <= active_d;
         standby_out                <= standby_d;
         reset_mode_out             <= ~hr; // RQ7
         data_valid_out             <= ok_d;
         sync_mode_out              <= cfg_sync_d;
         pe_q                       <= pe_d;
         pe_busy_out                <= (pe_d == PE_RUN);
         pe_refused_out             <= pe_ref_d;
         pe_abort_out               <= pe_abort_d;
         pe_high_supply_out         <= pe_high_d;
      end
   end

   // Block protection group
   always_comb begin
      lock_d     = lock_q;
      ldown_d    = ldown_q;
      lock_ref_d = 1'b0;
      lock_st_d  = 2'h0;
      if (!hr) begin
         lock_d  = '1; // RQ8
         ldown_d = '0;
      end else if (lock_req_in && blk_ok(lock_block_in)) begin
         if (ldown_q[lock_block_in] && !wp) begin
            lock_ref_d = 1'b1; // RQ5
         end else begin
            unique case (lock_op_in)
               LOCK_OP_LOCK:   lock_d[lock_block_in] = 1'b1; // RQ6
               LOCK_OP_UNLOCK: lock_d[lock_block_in] = 1'b0; // RQ6
               LOCK_OP_DOWN: begin
                  lock_d[lock_block_in]  = 1'b1;
                  ldown_d[lock_block_in] = 1'b1;
               end
               default: lock_ref_d = 1'b1;
            endcase
         end
      end else if (lock_req_in) begin
         lock_ref_d = 1'b1;
      end
      if (blk_ok(lock_block_in)) begin
         lock_st_d = {ldown_d[lock_block_in], lock_d[lock_block_in]};
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         lock_q           <= '1;
         ldown_q          <= '0;
         lock_refused_out <= 1'b0;
         lock_state_out   <= 2'h0;
      end else begin
         lock_q           <= lock_d;
         ldown_q          <= ldown_d;
         lock_refused_out <= lock_ref_d;
         lock_state_out   <= lock_st_d;
      end
   end

   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);

   AST_ACTIVE: assert property (sel |=> active_out) // RQ1
      else $error("Select with reset high did not give active");
   AST_DESEL_TRI: assert property (cs_n |=> !muxed_addr_data_bus_oe_out
                                   && !wait_oe_out) // RQ2
      else $error("Bus or wait driven while deselected");
   AST_OE_GATE: assert property (oe_n |=> !muxed_addr_data_bus_oe_out) // RQ3
      else $error("Bus driven with output enable high");
   AST_WR_CAPTURE: assert property (hr && wr_end |=> wr_strobe_out
                     && wr_addr_out == $past(addr_out)
                     && wr_data_out == $past(bus_p)) // RQ4
      else $error("Write end did not capture address and data");
   AST_LOCKDOWN: assert property (hr && lock_req_in && blk_ok(lock_block_in)
                     && ldown_q[lock_block_in] && !wp
                     |=> lock_refused_out && $stable(lock_q)) // RQ5
      else $error("Locked-down block changed under guard");
   AST_RESET_MODE: assert property (!hr |=> reset_mode_out
                     && !muxed_addr_data_bus_oe_out && !wait_oe_out) // RQ7
      else $error("Reset mode outputs not tri-stated");
   AST_RESET_LOCK: assert property (!hr |=> (&lock_q) && ldown_q == '0
                     && cfg_sync_q == CFG_SYNC_RST) // RQ8
      else $error("Reset did not lock blocks or restore config");
   AST_NO_DATA_EARLY: assert property (!hr ##1 (hr && !cs_fall
                     && !lat_fall)[*2] |=> !data_valid_out) // RQ9
      else $error("Data valid before select or latch fall");
   AST_LATCH_THRU: assert property (hr && !cfg_sync_q && !lat_n
                     |=> addr_out == $past(addr_in)) // RQ10
      else $error("Latch not transparent while low");
   AST_WAIT_OFF: assert property (oe_n |=> wait_out == WAIT_OFF) // RQ15
      else $error("Wait asserted with output enable high");
   AST_PE_LOCKOUT: assert property (hr && pe_q == PE_IDLE && pe_start_in
                     && program_lockout_level_in
                     |=> pe_refused_out && !pe_busy_out) // RQ16
      else $error("Program started in supply lockout");
   AST_PE_HOLD: assert property (pe_q == PE_RUN && hr && !pe_done_in
                     |=> pe_busy_out && $stable(pe_high_supply_out)) // RQ17
      else $error("Running operation disturbed");
   AST_PE_ABORT: assert property (pe_q == PE_RUN && !hr
                     |=> pe_abort_out && !pe_busy_out) // RQ23
      else $error("Reset did not abort program or erase");

   COV_WRITE: cover property (wr_strobe_out);
   COV_PE_RUN: cover property (pe_q == PE_RUN ##[1:20] pe_q == PE_IDLE);
   COV_SYNC_WAIT: cover property (cfg_sync_q && wait_oe_out && wait_out);
   COV_READ: cover property (muxed_addr_data_bus_oe_out);
endmodule

// ---- rtl/mfb_pkg.sv ----
// Purpose: Shared constants and types for the muxed flash bus interface
// Assumes: Pins are sampled by the core clock through three flip-flops
// Notes:   Defaults below are what a hard reset restores
package mfb_pkg;
   localparam int BUS_W      = 16;
   localparam int UPPER_W    = 8;
   localparam int ADDR_W     = BUS_W + UPPER_W;
   localparam int NUM_BLOCKS = 259;
   localparam int BLK_W      = 9;
   // Bit positions of the control pins in the sampled vector
   localparam int P_CS   = 0;
   localparam int P_OE   = 1;
   localparam int P_WE   = 2;
   localparam int P_LAT  = 3;
   localparam int P_RST  = 4;
   localparam int P_CLK  = 5;
   localparam int P_WP   = 6;
   localparam int CTL_W  = 7;
   localparam int PIN_W  = CTL_W + BUS_W + UPPER_W;
   localparam int P_BUS  = CTL_W;
   localparam int P_UPR  = CTL_W + BUS_W;
   // Pin idle levels seen before the first sample settles
   localparam logic [CTL_W-1:0] CTL_IDLE = 7'h5f;
   // Configuration defaults and the deasserted wait level
   localparam logic CFG_SYNC_RST  = 1'b0;
   localparam logic CFG_RISE_RST  = 1'b1;
   localparam logic CFG_EARLY_RST = 1'b0;
   localparam logic WAIT_OFF      = 1'b0;
   typedef enum logic [1:0] {
      LOCK_OP_LOCK,
      LOCK_OP_UNLOCK,
      LOCK_OP_DOWN
   } mfb_lock_op_type;
   typedef enum logic {
      PE_IDLE,
      PE_RUN
   } mfb_pe_state_type;
endpackage

// ---- verif/mfb_core_tb.sv ----
// Purpose: Self-checking bench for the muxed flash bus interface
// Assumes: Pins need about five core edges to settle, so holds are 6+
// Notes:   Write and abort pulses are counted by a monitor
`timescale 1ns/1ps
module mfb_core_tb;
   import mfb_pkg::*;
   localparam logic [ADDR_W-1:0] A1 = 24'h5a1234;
   localparam logic [ADDR_W-1:0] A2 = 24'h3c0f0e;
   localparam logic [BUS_W-1:0]  D1 = 16'hbeef;
   localparam logic [BUS_W-1:0]  RD = 16'h3c5a;
   logic             clock_in, rst_in, hard_reset_n_in, lockdown_guard_in;
   logic             chip_sel_n_in, out_en_n_in, cmd_strobe_n_in, latch_n_in;
   logic             flash_clk_in, clk_run, wait_now_in, wait_next_in;
   logic             cfg_load_in, cfg_sync_in, cfg_rise_in, cfg_early_in;
   logic             program_lockout_level_in, program_normal_level_in;
   logic             program_high_level_in, lock_req_in, pe_start_in;
   logic             pe_done_in, wr_strobe_out, active_out, standby_out;
   logic             reset_mode_out, data_valid_out, sync_mode_out;
   logic             lock_refused_out, pe_busy_out, pe_refused_out;
   logic             pe_abort_out, pe_high_supply_out, wait_out, wait_oe_out;
   logic             muxed_addr_data_bus_oe_out;
   logic [BUS_W-1:0] muxed_addr_data_bus_in, muxed_addr_data_bus_out;
   logic [BUS_W-1:0] read_data_in, wr_data_out;
   logic [7:0]       upper_address_lines_in;
   logic [8:0]       lock_block_in, pe_block_in;
   logic [1:0]       lock_state_out;
   logic [23:0]      addr_out, wr_addr_out;
   mfb_lock_op_type  lock_op_in;
   int               error_cnt, tests_run, wr_cnt, abort_cnt, cyc_cnt;

   mfb_core i_dut (.clock_in, .rst_in, .chip_sel_n_in, .out_en_n_in,
      .cmd_strobe_n_in, .latch_n_in, .hard_reset_n_in, .flash_clk_in,
      .lockdown_guard_in, .muxed_addr_data_bus_in, .muxed_addr_data_bus_out,
      .muxed_addr_data_bus_oe_out, .upper_address_lines_in, .wait_out,
      .wait_oe_out, .program_lockout_level_in, .program_normal_level_in,
      .program_high_level_in, .read_data_in, .wait_now_in, .wait_next_in,
      .cfg_load_in, .cfg_sync_in, .cfg_rise_in, .cfg_early_in, .lock_req_in,
      .lock_op_in, .lock_block_in, .pe_start_in, .pe_done_in, .pe_block_in,
      .addr_out, .wr_strobe_out, .wr_addr_out, .wr_data_out, .active_out,
      .standby_out, .reset_mode_out, .data_valid_out, .sync_mode_out,
      .lock_refused_out, .lock_state_out, .pe_busy_out, .pe_refused_out,
      .pe_abort_out, .pe_high_supply_out);
   mfb_host i_host (.clock_in(clock_in), .clk_run_in(clk_run),
      .dev_bus_in(muxed_addr_data_bus_out),
      .dev_oe_in(muxed_addr_data_bus_oe_out),
      .ctl_n_out({chip_sel_n_in, out_en_n_in, cmd_strobe_n_in, latch_n_in}),
      .flash_clk_out(flash_clk_in), .bus_out(muxed_addr_data_bus_in),
      .upper_out(upper_address_lines_in));

   initial begin
      clock_in = 1'b0;
      forever #2.5 clock_in = ~clock_in;
   end
   always @(posedge clock_in) begin
      cyc_cnt++;
      if (wr_strobe_out === 1'b1) wr_cnt++;
      if (pe_abort_out === 1'b1) abort_cnt++;
      if (cyc_cnt == 6000) begin
         error_cnt++;
         close_out();
      end
   end

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic hc(input logic [3:0] v, input logic en,
                     input logic [ADDR_W-1:0] a, input int n);
      i_host.cyc(v, en, a, n);
      @(negedge clock_in);
   endtask
   task automatic set_pin(input logic g, input logic h);
      @(posedge clock_in);
      lockdown_guard_in <= g;
      hard_reset_n_in <= h;
      repeat (8) @(negedge clock_in);
   endtask
   task automatic lock_do(input mfb_lock_op_type op, input logic [8:0] blk,
                          input logic ref_e, input logic [1:0] st_e);
      @(posedge clock_in);
      lock_op_in <= op;
      lock_block_in <= blk;
      lock_req_in <= 1'b1;
      @(posedge clock_in);
      lock_req_in <= 1'b0;
      @(negedge clock_in);
      chk(24'(lock_refused_out), 24'(ref_e));
      if (!ref_e) chk(24'(lock_state_out), 24'(st_e));
   endtask
   task automatic pe_do(input logic [2:0] lvl, input logic [8:0] blk,
                        input logic ref_e, input logic hi_e);
      @(posedge clock_in);
      {program_lockout_level_in, program_normal_level_in} <= lvl[2:1];
      program_high_level_in <= lvl[0];
      pe_block_in <= blk;
      pe_start_in <= 1'b1;
      @(posedge clock_in);
      pe_start_in <= 1'b0;
      @(negedge clock_in);
      chk(24'(pe_refused_out), 24'(ref_e));
      chk(24'(pe_busy_out), 24'(!ref_e));
      if (!ref_e) chk(24'(pe_high_supply_out), 24'(hi_e));
   endtask
   task automatic cfg(input logic [1:0] e);
      @(posedge clock_in);
      {cfg_sync_in, cfg_rise_in, cfg_early_in, cfg_load_in} <=
         {1'b1, e, 1'b1};
      @(posedge clock_in);
      cfg_load_in <= 1'b0;
      @(negedge clock_in);
   endtask
   task automatic close_out();
      $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      {rst_in, hard_reset_n_in, lockdown_guard_in, clk_run} = 4'hc;
      {wait_now_in, wait_next_in, cfg_load_in, cfg_sync_in} = 4'h8;
      {cfg_rise_in, cfg_early_in, lock_req_in, pe_start_in, pe_done_in} = '0;
      {program_lockout_level_in, program_normal_level_in} = 2'b01;
      program_high_level_in = 1'b0;
      {lock_block_in, pe_block_in, lock_op_in} = '0;
      read_data_in = RD;
      {error_cnt, tests_run, wr_cnt, abort_cnt, cyc_cnt} = '0;
      repeat (2) @(posedge clock_in);
      rst_in <= 1'b0;
      repeat (6) @(negedge clock_in);
      chk(24'(standby_out), 24'h1);
      chk(24'(wait_oe_out), 24'h0);
      hc(4'b0110, 1'b1, A1, 6);
      hc(4'b0111, 1'b1, A1, 6);
      chk(addr_out, A1);
      chk(24'(active_out), 24'h1);
      hc(4'b0101, 1'b1, {A1[23:16], D1}, 6);
      hc(4'b0111, 1'b1, {A1[23:16], D1}, 8);
      chk(24'(wr_cnt), 24'h1);
      chk(wr_addr_out, A1);
      chk(24'(wr_data_out), 24'(D1));
      chk(addr_out, A1);
      hc(4'b0011, 1'b0, A1, 6);
      chk(24'(muxed_addr_data_bus_oe_out), 24'h1);
      chk(24'(muxed_addr_data_bus_out), 24'(RD));
      hc(4'b0111, 1'b0, A1, 6);
      chk(24'(muxed_addr_data_bus_oe_out), 24'h0);
      lock_do(LOCK_OP_UNLOCK, 9'd5, 1'b0, 2'b00);
      lock_do(LOCK_OP_DOWN, 9'd5, 1'b0, 2'b11);
      set_pin(1'b0, 1'b1);
      lock_do(LOCK_OP_UNLOCK, 9'd5, 1'b1, 2'b11);
      lock_do(LOCK_OP_LOCK, 9'd9, 1'b0, 2'b01);
      set_pin(1'b1, 1'b1);
      lock_do(LOCK_OP_UNLOCK, 9'd5, 1'b0, 2'b10);
      lock_do(LOCK_OP_UNLOCK, 9'd259, 1'b1, 2'b00);
      pe_do(3'b100, 9'd5, 1'b1, 1'b0);
      pe_do(3'b000, 9'd5, 1'b1, 1'b0);
      pe_do(3'b010, 9'd9, 1'b1, 1'b0);
      pe_do(3'b001, 9'd5, 1'b0, 1'b1);
      @(posedge clock_in);
      pe_done_in <= 1'b1;
      @(posedge clock_in);
      pe_done_in <= 1'b0;
      pe_do(3'b010, 9'd5, 1'b0, 1'b0);
      pe_do(3'b101, 9'd5, 1'b0, 1'b0);
      hc(4'b1111, 1'b0, A1, 6);
      chk(24'(pe_busy_out), 24'h1);
      chk(24'(standby_out), 24'h0);
      @(posedge clock_in);
      pe_done_in <= 1'b1;
      @(posedge clock_in);
      pe_done_in <= 1'b0;
      repeat (2) @(negedge clock_in);
      chk(24'(standby_out), 24'h1);
      pe_do(3'b010, 9'd5, 1'b0, 1'b0);
      hc(4'b0011, 1'b0, A1, 6);
      set_pin(1'b0, 1'b0);
      chk(24'(abort_cnt), 24'h1);
      chk(24'(pe_busy_out), 24'h0);
      chk(24'(reset_mode_out), 24'h1);
      chk(24'(muxed_addr_data_bus_oe_out), 24'h0);
      chk(24'(wait_oe_out), 24'h0);
      set_pin(1'b0, 1'b1);
      chk(24'(data_valid_out), 24'h0);
      pe_do(3'b010, 9'd5, 1'b1, 1'b0);
      lock_do(LOCK_OP_UNLOCK, 9'd5, 1'b0, 2'b00);
      hc(4'b1111, 1'b0, A1, 6);
      hc(4'b0011, 1'b0, A1, 6);
      chk(24'(data_valid_out), 24'h1);
      hc(4'b1111, 1'b0, A1, 6);
      clk_run = 1'b1;
      cfg(2'b10);
      chk(24'(sync_mode_out), 24'h1);
      hc(4'b0110, 1'b1, A2, 30);
      hc(4'b0111, 1'b1, A1, 6);
      chk(addr_out, A2);
      for (int e = 0; e < 2; e++) begin
         cfg({1'b1, e[0]});
         hc(4'b0011, 1'b0, A2, 12);
         chk(24'(wait_oe_out), 24'h1);
         chk(24'(wait_out), 24'(e == 0));
         hc(4'b0111, 1'b0, A2, 6);
         chk(24'(wait_out), 24'h0);
      end
      cfg(2'b00);
      hc(4'b0110, 1'b1, A1, 30);
      hc(4'b0111, 1'b1, A2, 6);
      chk(addr_out, A1);
      clk_run = 1'b0;
      hc(4'b1111, 1'b0, A2, 6);
      chk(24'(wait_oe_out), 24'h0);
      close_out();
   end
endmodule

// ---- verif/mfb_host.sv ----
// Purpose: Host model driving the muxed flash bus pins
// Assumes: Pin changes other than the gated flash clock land by NBA just after a core clock edge
// Notes:   A released bus shows a pattern that flips every cycle
`timescale 1ns/1ps
module mfb_host (
   input  wire logic                        clock_in,
   input  wire logic                        clk_run_in,
   input  wire logic [mfb_pkg::BUS_W-1:0]   dev_bus_in,
   input  wire logic                        dev_oe_in,
   output logic      [3:0]                  ctl_n_out,
   output logic                             flash_clk_out,
   output logic      [mfb_pkg::BUS_W-1:0]   bus_out,
   output logic      [mfb_pkg::UPPER_W-1:0] upper_out
);
   import mfb_pkg::*;
   logic [BUS_W-1:0] drv_val;
   logic [BUS_W-1:0] last_q;
   logic             drv_en;
   // No pull on the bus, so an undriven bus must not look stable
   assign bus_out = dev_oe_in ? dev_bus_in : (drv_en ? drv_val : ~last_q);
   always @(posedge clock_in) last_q <= bus_out;
   // Clock stands low outside sync frames
   always #32 flash_clk_out = clk_run_in ? ~flash_clk_out : 1'b0;
   initial begin
      ctl_n_out = 4'hf;
      flash_clk_out = 1'b0;
      drv_en = 1'b0;
      {upper_out, drv_val, last_q} = '0;
   end
   // Pins {select, output enable, strobe, latch}, held n edges
   task automatic cyc(input logic [3:0] v, input logic en,
                      input logic [ADDR_W-1:0] a, input int n);
      @(posedge clock_in);
      ctl_n_out <= v;
      drv_en <= en;
      {upper_out, drv_val} <= a;
      repeat (n) @(posedge clock_in);
   endtask
endmodule
